// ### hdl/mcdsr_params.svh
`ifndef MCDSR_PARAMS_SVH
`define MCDSR_PARAMS_SVH

// register byte addresses
`define MCDSR_DIAG_ADDR        8'h1C
`define MCDSR_STAT_ADDR        8'h20
`define MCDSR_CFG_ADDR         8'h24

// diagnostic control fields
`define MCDSR_DIAG_SLOW_EDGE   4
`define MCDSR_DIAG_FSENSE_DIS  3
`define MCDSR_DIAG_FEF_DIS     2
`define MCDSR_DIAG_BACKUP_DIS  1
`define MCDSR_DIAG_RESET       16'h0000

// converter configuration fields
`define MCDSR_CFG_NONTRANSP    11
`define MCDSR_CFG_ECL_MODE     3
`define MCDSR_CFG_SCRAMBLE     1
`define MCDSR_CFG_RESET        16'h0000

// status fields
`define MCDSR_ST_FIB_LO        15
`define MCDSR_ST_FIB_FREQ      14
`define MCDSR_ST_FEF_SEEN      13
`define MCDSR_ST_COP_LO        12
`define MCDSR_ST_COP_FREQ      11
`define MCDSR_ST_SEED_LOST     10
`define MCDSR_ST_LINK_UP       9
`define MCDSR_ST_NEG_DONE      8
`define MCDSR_ST_COP_FAST      7
`define MCDSR_ST_COP_SLOW      6
`define MCDSR_ST_COP_PKT       5
`define MCDSR_ST_BURST         4
`define MCDSR_ST_FIB_FAST      3
`define MCDSR_ST_FIB_SLOW      2
`define MCDSR_ST_FIB_PKT       1
`define MCDSR_ST_FIB_PULSE     0

// timing
`define MCDSR_CLK_MHZ          250
`define MCDSR_SEED_TIMEOUT_US  1300
`define MCDSR_SEED_TIMEOUT_CYC (`MCDSR_SEED_TIMEOUT_US * `MCDSR_CLK_MHZ)

`endif

// ### hdl/mcdsr_pkg.sv
package mcdsr_pkg;

    typedef logic [15:0] mcdsr_word_t;

    typedef enum logic [1:0] {
        MCDSR_OKAY,
        MCDSR_EXOKAY,
        MCDSR_SLVERR,
        MCDSR_DECERR
    } mcdsr_resp_t;

endpackage

// ### hdl/mcdsr_regs.sv
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "mcdsr_params.svh"

module mcdsr_regs
    import mcdsr_pkg::*;
#(
    parameter int ADDR_W           = 8,
    parameter int SEED_TIMEOUT_CYC = `MCDSR_SEED_TIMEOUT_CYC
) (
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              fiber_pll_on_local_osc,
    input  wire logic              fiber_freq_out_of_band,
    input  wire logic              fiber_pll_filter_rst,
    input  wire logic              far_fault_pattern,
    input  wire logic              copper_pll_on_local_osc,
    input  wire logic              copper_freq_out_of_band,
    input  wire logic              copper_pll_filter_rst,
    input  wire logic              seed_update,
    input  wire logic              copper_link_raw,
    input  wire logic              negotiation_done_raw,
    input  wire logic              copper_fast_signal,
    input  wire logic              copper_slow_signal,
    input  wire logic              copper_packet_pulse,
    input  wire logic              copper_flp_burst,
    input  wire logic              copper_fiber_style_burst,
    input  wire logic              fiber_fast_signal,
    input  wire logic              fiber_slow_signal,
    input  wire logic              fiber_packet_pulse,
    input  wire logic              fiber_link_pulse_seen,
    input  wire logic              backup_link_cfg_pin,
    output logic                   slow_tx_edges,
    output logic                   freq_sense_disable,
    output logic                   far_fault_disable,
    output logic                   backup_link_enable,
    output logic                   non_transparent,
    output logic                   copper_ecl_mode,
    output logic                   scrambler_enable
);

    localparam int CNT_W = $clog2(SEED_TIMEOUT_CYC + 1);

    default clocking cb_core @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    if ((SEED_TIMEOUT_CYC < 2) || (ADDR_W < 8)) begin : g_bad_param
        $error("seed timeout needs two cycles and the address eight bits");
    end

    ////////////////////////////////////////////////////////////////////////
    // write channel

    logic              aw_held_r;
    logic              w_held_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [31:0]       w_data_r;
    logic [3:0]        w_strb_r;
    logic              awready_r;
    logic              wready_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              aw_take, w_take, do_wr;
    logic              aw_held_nxt, w_held_nxt;
    logic              wr_map;

    assign aw_take     = s_axi_awvalid & awready_r;
    assign w_take      = s_axi_wvalid & wready_r;
    assign do_wr       = aw_held_r & w_held_r & ~bvalid_r;
    assign aw_held_nxt = aw_take | (aw_held_r & ~do_wr);
    assign w_held_nxt  = w_take | (w_held_r & ~do_wr);
    // the status word is mapped but takes no data
    assign wr_map      = (aw_addr_r[7:0] == `MCDSR_DIAG_ADDR) | (aw_addr_r[7:0] == `MCDSR_STAT_ADDR)
                       | (aw_addr_r[7:0] == `MCDSR_CFG_ADDR);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
        end else begin
            aw_held_r <= aw_held_nxt;
            w_held_r  <= w_held_nxt;
            awready_r <= ~aw_held_nxt;
            wready_r  <= ~w_held_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            aw_addr_r <= '0;
            w_data_r  <= 32'h00000000;
            w_strb_r  <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_addr_r <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            bvalid_r <= 1'b0;
            bresp_r  <= 2'(MCDSR_OKAY);
        end else if (do_wr) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_map ? 2'(MCDSR_OKAY) : 2'(MCDSR_DECERR);
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers

    mcdsr_word_t diag_control_r;
    mcdsr_word_t conv_config_r;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            diag_control_r <= `MCDSR_DIAG_RESET;
            conv_config_r  <= `MCDSR_CFG_RESET;
        end else if (do_wr) begin
            if (aw_addr_r[7:0] == `MCDSR_DIAG_ADDR) begin
                if (w_strb_r[0]) diag_control_r[7:0]  <= w_data_r[7:0];
                if (w_strb_r[1]) diag_control_r[15:8] <= w_data_r[15:8];
            end
            if (aw_addr_r[7:0] == `MCDSR_CFG_ADDR) begin
                if (w_strb_r[0]) conv_config_r[7:0]  <= w_data_r[7:0];
                if (w_strb_r[1]) conv_config_r[15:8] <= w_data_r[15:8];
            end
        end
    end

    logic nontr, ecl, fsdis, fefdis;
    assign nontr  = conv_config_r[`MCDSR_CFG_NONTRANSP];
    assign ecl    = conv_config_r[`MCDSR_CFG_ECL_MODE];
    assign fsdis  = diag_control_r[`MCDSR_DIAG_FSENSE_DIS];
    assign fefdis = diag_control_r[`MCDSR_DIAG_FEF_DIS];

    // outputs to the analog and link logic lag the register by one cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            slow_tx_edges      <= 1'b0;
            freq_sense_disable <= 1'b0;
            far_fault_disable  <= 1'b0;
            backup_link_enable <= 1'b0;
            non_transparent    <= 1'b0;
            copper_ecl_mode    <= 1'b0;
            scrambler_enable   <= 1'b0;
        end else begin
            slow_tx_edges      <= diag_control_r[`MCDSR_DIAG_SLOW_EDGE];
            freq_sense_disable <= fsdis;
            far_fault_disable  <= fefdis;
            backup_link_enable <= backup_link_cfg_pin & ~diag_control_r[`MCDSR_DIAG_BACKUP_DIS];
            non_transparent    <= nontr;
            copper_ecl_mode    <= ecl;
            scrambler_enable   <= conv_config_r[`MCDSR_CFG_SCRAMBLE];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel and latched status

    logic              arready_r;
    logic              rvalid_r;
    logic [31:0]       rdata_r;
    logic [1:0]        rresp_r;
    logic              ar_take;
    logic              rvalid_nxt;
    logic              stat_rd;
    logic [CNT_W-1:0]  seed_cnt_r;
    logic              seed_expired;
    logic              seed_lost_r, link_up_r, cop_pkt_r, fib_pkt_r;
    logic              cop_speed, fib_speed;
    mcdsr_word_t       status_word;

    assign ar_take    = s_axi_arvalid & arready_r;
    assign rvalid_nxt = ar_take | (rvalid_r & ~s_axi_rready);
    assign stat_rd    = ar_take & (s_axi_araddr[7:0] == `MCDSR_STAT_ADDR);
    assign cop_speed  = copper_fast_signal | copper_slow_signal;
    assign fib_speed  = fiber_fast_signal | fiber_slow_signal;

    // counter saturates so the expired level holds until the seed moves or the scrambler is switched off
    assign seed_expired = (seed_cnt_r == CNT_W'(SEED_TIMEOUT_CYC));

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            seed_cnt_r <= '0;
        end else if (seed_update | ~conv_config_r[`MCDSR_CFG_SCRAMBLE]) begin
            seed_cnt_r <= '0;
        end else if (!seed_expired) begin
            seed_cnt_r <= seed_cnt_r + CNT_W'(1);
        end
    end

    // a new event in the read cycle always survives the clear
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            seed_lost_r <= 1'b0;
            link_up_r   <= 1'b0;
            cop_pkt_r   <= 1'b0;
            fib_pkt_r   <= 1'b0;
        end else begin
            seed_lost_r <= seed_expired | (seed_lost_r & ~stat_rd);
            link_up_r   <= copper_link_raw & (link_up_r | stat_rd);
            cop_pkt_r   <= cop_speed & (copper_packet_pulse | (cop_pkt_r & ~stat_rd));
            fib_pkt_r   <= fib_speed & (fiber_packet_pulse | (fib_pkt_r & ~stat_rd));
        end
    end

    always_comb begin
        status_word = 16'h0000;
        status_word[`MCDSR_ST_FIB_LO]    = fiber_pll_on_local_osc;
        status_word[`MCDSR_ST_FIB_FREQ]  = fiber_freq_out_of_band & ~fsdis & ~fiber_pll_filter_rst;
        status_word[`MCDSR_ST_FEF_SEEN]  = far_fault_pattern & ~fefdis;
        status_word[`MCDSR_ST_COP_LO]    = copper_pll_on_local_osc;
        status_word[`MCDSR_ST_COP_FREQ]  = copper_freq_out_of_band & ~fsdis & ~copper_pll_filter_rst;
        status_word[`MCDSR_ST_SEED_LOST] = seed_lost_r;
        status_word[`MCDSR_ST_LINK_UP]   = link_up_r & nontr;
        status_word[`MCDSR_ST_NEG_DONE]  = negotiation_done_raw & nontr;
        status_word[`MCDSR_ST_COP_FAST]  = copper_fast_signal;
        status_word[`MCDSR_ST_COP_SLOW]  = copper_slow_signal;
        status_word[`MCDSR_ST_COP_PKT]   = cop_pkt_r & cop_speed;
        status_word[`MCDSR_ST_BURST]     = copper_flp_burst | (ecl & copper_fiber_style_burst);
        status_word[`MCDSR_ST_FIB_FAST]  = fiber_fast_signal;
        status_word[`MCDSR_ST_FIB_SLOW]  = fiber_slow_signal;
        status_word[`MCDSR_ST_FIB_PKT]   = fib_pkt_r & fib_speed;
        status_word[`MCDSR_ST_FIB_PULSE] = fiber_link_pulse_seen;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
        end else begin
            arready_r <= ~rvalid_nxt;
            rvalid_r  <= rvalid_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdata_r <= 32'h00000000;
            rresp_r <= 2'(MCDSR_OKAY);
        end else if (ar_take) begin
            rresp_r <= 2'(MCDSR_OKAY);
            unique case (s_axi_araddr[7:0])
                `MCDSR_DIAG_ADDR: rdata_r <= {16'h0000, diag_control_r};
                `MCDSR_STAT_ADDR: rdata_r <= {16'h0000, status_word};
                `MCDSR_CFG_ADDR:  rdata_r <= {16'h0000, conv_config_r};
                default: begin
                    rdata_r <= 32'h00000000;
                    rresp_r <= 2'(MCDSR_DECERR);
                end
            endcase
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    ////////////////////////////////////////////////////////////////////////
    // checks

    property p_slow_edges;
        slow_tx_edges == $past(diag_control_r[`MCDSR_DIAG_SLOW_EDGE]);
    endproperty
    a_slow_edges: assert property (p_slow_edges) else $error("slow edge output wrong");
    property p_fsense;
        fsdis |-> (status_word[`MCDSR_ST_FIB_FREQ] == 1'b0) && (status_word[`MCDSR_ST_COP_FREQ] == 1'b0);
    endproperty
    a_fsense: assert property (p_fsense) else $error("frequency alarm while sensing off");
    property p_fef;
        fefdis |-> !status_word[`MCDSR_ST_FEF_SEEN] ##1 far_fault_disable;
    endproperty
    a_fef: assert property (p_fef) else $error("far fault not disabled");
    property p_backup;
        diag_control_r[`MCDSR_DIAG_BACKUP_DIS] |=> !backup_link_enable;
    endproperty
    a_backup: assert property (p_backup) else $error("backup link not overridden");
    property p_diag_wr;
        do_wr && (aw_addr_r[7:0] == `MCDSR_DIAG_ADDR) && (w_strb_r[1:0] == 2'h3)
        |=> diag_control_r == $past(w_data_r[15:0]);
    endproperty
    a_diag_wr: assert property (p_diag_wr) else $error("diag write lost");
    property p_seed;
        (seed_cnt_r == CNT_W'(SEED_TIMEOUT_CYC - 1)) && !seed_update && conv_config_r[`MCDSR_CFG_SCRAMBLE]
        |=> ##1 seed_lost_r;
    endproperty
    a_seed: assert property (p_seed) else $error("seed loss not flagged");
    property p_link_low;
        !copper_link_raw |=> !link_up_r;
    endproperty
    a_link_low: assert property (p_link_low) else $error("link drop not latched");
    property p_transp;
        !nontr |-> !status_word[`MCDSR_ST_LINK_UP] && !status_word[`MCDSR_ST_NEG_DONE];
    endproperty
    a_transp: assert property (p_transp) else $error("link bits active in transparent mode");
    property p_pkt_hold;
        cop_pkt_r && !stat_rd && cop_speed |=> cop_pkt_r;
    endproperty
    a_pkt_hold: assert property (p_pkt_hold) else $error("copper packet flag dropped");
    property p_stat_ro;
        do_wr && (aw_addr_r[7:0] == `MCDSR_STAT_ADDR) |=> $stable(diag_control_r) && $stable(conv_config_r);
    endproperty
    a_stat_ro: assert property (p_stat_ro) else $error("status write changed a register");
    property p_rd_answer;
        ar_take |=> rvalid_r;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");

    c_seed_lost: cover property (stat_rd && seed_lost_r);
    c_link_drop: cover property (link_up_r ##1 !link_up_r);
    c_diag_wr:   cover property (do_wr && (aw_addr_r[7:0] == `MCDSR_DIAG_ADDR));
    c_bad_addr:  cover property (s_axi_bvalid && (s_axi_bresp == 2'(MCDSR_DECERR)));

endmodule

// ### dv/mcdsr_host.sv
`timescale 1ns/1ps

module mcdsr_host (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        go_wr,
    input  wire logic        go_rd,
    input  wire logic [7:0]  cmd_addr,
    input  wire logic [31:0] cmd_data,
    output logic             busy,
    output logic [31:0]      rd_word,
    output logic [1:0]       rd_resp,
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    // one transfer at a time; payload is scrambled once taken so stale values never look valid
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, busy} <= '0;
            {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rd_word, rd_resp} <= '0;
            s_axi_wstrb <= 4'hF;
        end else begin
            if (go_wr && !busy) begin
                {s_axi_awvalid, s_axi_wvalid, s_axi_bready, busy} <= 4'hF;
                s_axi_awaddr <= cmd_addr;
                s_axi_wdata  <= cmd_data;
            end else if (go_rd && !busy) begin
                {s_axi_arvalid, s_axi_rready, busy} <= 3'h7;
                s_axi_araddr <= cmd_addr;
            end
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr  <= ~s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata  <= ~s_axi_wdata;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr  <= ~s_axi_araddr;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                {s_axi_bready, busy} <= 2'h0;
                rd_resp <= s_axi_bresp;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                {s_axi_rready, busy} <= 2'h0;
                rd_resp <= s_axi_rresp;
                rd_word <= s_axi_rdata;
            end
        end
    end
endmodule

// ### dv/media_converter_diag_status_regs_test.sv
`timescale 1ns/1ps
`include "mcdsr_params.svh"

module media_converter_diag_status_regs_test;
    import mcdsr_pkg::*;
    logic core_clk = 1'b0, sys_rst = 1'b1, go_wr = 1'b0, go_rd = 1'b0, busy;
    logic [7:0] cmd_addr = 8'h00, s_axi_awaddr, s_axi_araddr;
    logic [31:0] cmd_data = 32'h0, rd_word, s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] rd_resp, s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic fiber_pll_on_local_osc, fiber_freq_out_of_band, fiber_pll_filter_rst, far_fault_pattern;
    logic copper_pll_on_local_osc, copper_freq_out_of_band, copper_pll_filter_rst, seed_update;
    logic copper_link_raw, negotiation_done_raw, copper_fast_signal, copper_slow_signal;
    logic copper_packet_pulse, copper_flp_burst, copper_fiber_style_burst, fiber_fast_signal;
    logic fiber_slow_signal, fiber_packet_pulse, fiber_link_pulse_seen, backup_link_cfg_pin;
    logic slow_tx_edges, freq_sense_disable, far_fault_disable, backup_link_enable;
    logic non_transparent, copper_ecl_mode, scrambler_enable;
    int n_fail = 0, tests_run = 0;

    initial begin
        {fiber_pll_on_local_osc, fiber_freq_out_of_band, fiber_pll_filter_rst, far_fault_pattern,
         copper_pll_on_local_osc, copper_freq_out_of_band, copper_pll_filter_rst, seed_update,
         copper_link_raw, negotiation_done_raw, copper_fast_signal, copper_slow_signal,
         copper_packet_pulse, copper_flp_burst, copper_fiber_style_burst, fiber_fast_signal,
         fiber_slow_signal, fiber_packet_pulse, fiber_link_pulse_seen} <= '0;
        backup_link_cfg_pin <= 1'b1;
    end

    always #2 core_clk = ~core_clk;

    mcdsr_regs #(.SEED_TIMEOUT_CYC(20)) DUT (.*);
    mcdsr_host host (.*);

    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one host transfer; the wait is bounded so a dead handshake shows up as a mismatch
    task xfer(input logic w, input logic [7:0] a, input logic [15:0] v);
        int k;
        k = 0;
        @(posedge core_clk);
        cmd_addr <= a;
        cmd_data <= {16'h0000, v};
        if (w) go_wr <= 1'b1;
        else go_rd <= 1'b1;
        @(posedge core_clk);
        {go_wr, go_rd} <= 2'b00;
        do begin
            @(negedge core_clk);
            k++;
        end while (busy !== 1'b0 && k < 60);
        if (k >= 60) chk(32'h0, 32'h1);
        d = rd_word;
    endtask

    task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        xfer(1'b0, a, 16'h0000);
        chk(d & m, e);
    endtask

    task results;
        $display("fails %0d checks %0d", n_fail, tests_run);
        if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        results;
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        rchk(`MCDSR_DIAG_ADDR, 32'hFFFFFFFF, 32'h0);
        chk({slow_tx_edges, freq_sense_disable, far_fault_disable, non_transparent}, 32'h0);
        for (int b = 1; b < 5; b++) begin
            xfer(1'b1, `MCDSR_DIAG_ADDR, 16'h0001 << b);
            chk({slow_tx_edges, freq_sense_disable, far_fault_disable, backup_link_enable},
                {b == 4, b == 3, b == 2, b != 1});
        end
        xfer(1'b1, `MCDSR_DIAG_ADDR, 16'hFFFF);
        rchk(`MCDSR_DIAG_ADDR, 32'hFFFFFFFF, 32'h0000FFFF);
        xfer(1'b1, `MCDSR_STAT_ADDR, 16'hFFFF);
        chk(rd_resp, MCDSR_OKAY);
        rchk(`MCDSR_STAT_ADDR, 32'hFFFFFFFF, 32'h0);
        rchk(8'h40, 32'hFFFFFFFF, 32'h0);
        chk(rd_resp, MCDSR_DECERR);
        xfer(1'b1, 8'h40, 16'hFFFF);
        chk(rd_resp, MCDSR_DECERR);
        // frequency alarms and far fault gated by the diag bits still set
        @(posedge core_clk) {fiber_freq_out_of_band, copper_freq_out_of_band, far_fault_pattern} <= 3'h7;
        rchk(`MCDSR_STAT_ADDR, 32'h6800, 32'h0);
        xfer(1'b1, `MCDSR_DIAG_ADDR, 16'h0000);
        rchk(`MCDSR_STAT_ADDR, 32'h6800, 32'h6800);
        @(posedge core_clk) fiber_pll_filter_rst <= 1'b1;
        rchk(`MCDSR_STAT_ADDR, 32'h6800, 32'h2800);
        @(posedge core_clk) copper_pll_filter_rst <= 1'b1;
        rchk(`MCDSR_STAT_ADDR, 32'h6800, 32'h2000);
        @(posedge core_clk) {fiber_pll_on_local_osc, copper_pll_on_local_osc} <= 2'b11;
        rchk(`MCDSR_STAT_ADDR, 32'h9000, 32'h9000);
        @(posedge core_clk) {copper_fast_signal, fiber_slow_signal} <= 2'b11;
        rchk(`MCDSR_STAT_ADDR, 32'h00CC, 32'h0084);
        @(posedge core_clk) {copper_fast_signal, copper_slow_signal, fiber_fast_signal, fiber_slow_signal} <= 4'h6;
        rchk(`MCDSR_STAT_ADDR, 32'h00CC, 32'h0048);
        // fiber-style bursts count only in copper ecl mode
        @(posedge core_clk) {copper_fiber_style_burst, fiber_link_pulse_seen} <= 2'b11;
        rchk(`MCDSR_STAT_ADDR, 32'h0011, 32'h0001);
        xfer(1'b1, `MCDSR_CFG_ADDR, 16'h0008);
        chk(copper_ecl_mode, 32'h1);
        rchk(`MCDSR_STAT_ADDR, 32'h0011, 32'h0011);
        @(posedge core_clk) {copper_fiber_style_burst, copper_flp_burst} <= 2'b01;
        xfer(1'b1, `MCDSR_CFG_ADDR, 16'h0000);
        rchk(`MCDSR_STAT_ADDR, 32'h0010, 32'h0010);
        // link and negotiation only in non-transparent operation
        @(posedge core_clk) {copper_link_raw, negotiation_done_raw} <= 2'b11;
        rchk(`MCDSR_STAT_ADDR, 32'h0300, 32'h0);
        xfer(1'b1, `MCDSR_CFG_ADDR, 16'h0800);
        chk(non_transparent, 32'h1);
        xfer(1'b0, `MCDSR_STAT_ADDR, 16'h0000);
        rchk(`MCDSR_STAT_ADDR, 32'h0300, 32'h0300);
        @(posedge core_clk) copper_link_raw <= 1'b0;
        @(posedge core_clk) copper_link_raw <= 1'b1;
        rchk(`MCDSR_STAT_ADDR, 32'h0300, 32'h0100);
        rchk(`MCDSR_STAT_ADDR, 32'h0300, 32'h0300);
        // packet flags latch until read, and only with a speed present
        @(posedge core_clk) {copper_packet_pulse, fiber_packet_pulse} <= 2'b11;
        @(posedge core_clk) {copper_packet_pulse, fiber_packet_pulse} <= 2'b00;
        rchk(`MCDSR_STAT_ADDR, 32'h0022, 32'h0022);
        rchk(`MCDSR_STAT_ADDR, 32'h0022, 32'h0);
        @(posedge core_clk) {copper_slow_signal, fiber_fast_signal, copper_packet_pulse, fiber_packet_pulse} <= 4'h3;
        @(posedge core_clk) {copper_packet_pulse, fiber_packet_pulse} <= 2'b00;
        rchk(`MCDSR_STAT_ADDR, 32'h0022, 32'h0);
        // seed watchdog, shortened to 20 cycles for the run
        xfer(1'b1, `MCDSR_CFG_ADDR, 16'h0002);
        chk(scrambler_enable, 32'h1);
        repeat (40) @(posedge core_clk);
        rchk(`MCDSR_STAT_ADDR, 32'h0400, 32'h0400);
        @(posedge core_clk) seed_update <= 1'b1;
        @(posedge core_clk) seed_update <= 1'b0;
        xfer(1'b0, `MCDSR_STAT_ADDR, 16'h0000);
        rchk(`MCDSR_STAT_ADDR, 32'h0400, 32'h0);
        results;
    end
endmodule
